/* File: hw/ssc_pkg.sv */
// Package of constants and types for the spindle sequence controller
package ssc_pkg;
    // Clock rate in Hz
    localparam int unsigned CLK_HZ = 25000000;
    // Sequence times in milliseconds
    localparam int unsigned SPEED_CHECK_MS = 21700;
    localparam int unsigned BRAKE_ENGAGE_MS = 340;
    localparam int unsigned BRAKE_CURRENT_MS = 425;
    localparam int unsigned DOOR_RELEASE_MS = 19000;
    // Cycle counts derived from the times
    localparam longint unsigned SPEED_CHECK_CYC =
        longint'(SPEED_CHECK_MS) * CLK_HZ / 1000;
    localparam longint unsigned BRAKE_ENGAGE_CYC =
        longint'(BRAKE_ENGAGE_MS) * CLK_HZ / 1000;
    localparam longint unsigned BRAKE_CURRENT_CYC =
        longint'(BRAKE_CURRENT_MS) * CLK_HZ / 1000;
    localparam longint unsigned DOOR_RELEASE_CYC =
        longint'(DOOR_RELEASE_MS) * CLK_HZ / 1000;
    // Counter width, enough for the longest time
    localparam int unsigned CNT_W = 30;
    // Retract pulse length in clocks
    localparam int unsigned RETRACT_PULSE_CYC = 1;
    // Sequencer states, Gray coded along the usual path
    typedef enum logic [1:0] {
        SSC_STOPPED = 2'b00,
        SSC_UP = 2'b01,
        SSC_RUN = 2'b11,
        SSC_DOWN = 2'b10
    } ssc_state_t;
    // Fault inputs from servo and power monitor
    typedef struct packed {
        logic dcFaultFlag;
        logic emergencyPullbackActive;
        logic emergencyPullbackPowerLost;
        logic recalFailedTwice;
        logic seekNotDone;
        logic servoHeadsOnDisc;
    } ssc_faults_t;
    // Motor and door drive outputs
    typedef struct packed {
        logic spindleRun;
        logic pullHeadsBack;
        logic brakeEngage;
        logic brakeCurrentDrive;
        logic doorLockDrive;
        logic startInhibitOut;
    } ssc_drive_t;
endpackage

/* File: hw/ssc_seq_timer.sv */
// Sequence timing counter with restart and saturation
`timescale 1ns/1ps
module ssc_seq_timer (
    input wire logic clk,
    input wire logic rstSync_b,
    input wire logic restart,
    output logic [ssc_pkg::CNT_W-1:0] count
);
    logic [ssc_pkg::CNT_W-1:0] count_reg;
    logic [ssc_pkg::CNT_W-1:0] count_next;

    // Restart wins; saturate so late compares stay true
    always_comb begin
        if (restart) begin
            count_next = '0;
        end else if (&count_reg) begin
            count_next = count_reg;
        end else begin
            count_next = count_reg + {{(ssc_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Register the count
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule

/* File: hw/ssc_spindle_sequence_controller.sv */
// Spindle sequencing: start gating, up/down timing, abnormal halt latch
// Behaviour
// - Start permitted: no fault, no halt, door, run
// - Up needs permit, no inhibit, parked, slow
// - Up sets sequence-up, spindle, retract pulse
// - Up restarts timer; check speed at 21.7 s
// - Abnormal halt disables sequencing, drops permit
// - Permit low fires down sequence
// - Down retracts heads first, then cuts spindle
// - Brake engage at 0.340 s of down
// - Brake current at 0.425 s of down
// - Door lock released at 19.0 s of down
// - Emergency pullback active or power lost halts
// - Recalibrate failed twice halts
// - Seek not done with heads parked halts
// - Parked yet heads on disc halts
// - Speed check done but slow halts
// - Door open: no start, indicator dark
// - Door lock held while pack rotates
// - Door opened while running: down sequence
// - Inhibit others while spinning up; obey theirs
`timescale 1ns/1ps
module ssc_spindle_sequence_controller (
    input wire logic clk,
    input wire logic rst_b,
    input wire ssc_pkg::ssc_faults_t faults,
    input wire logic runRequest,
    input wire logic doorClosed,
    input wire logic doorSecured,
    input wire logic headsParked,
    input wire logic atRatedSpeed,
    input wire logic otherDriveInhibit,
    output ssc_pkg::ssc_drive_t drive,
    output logic doorLockedLamp,
    output logic abnormalHalt,
    output logic speedCheckDone,
    output logic sequenceUp,
    output logic sequenceDown
);
    // Reset release through two flops
    logic rstMeta_reg;
    logic rstSync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_reg <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_b <= rstMeta_reg;
        end
    end

    // Timer compare helper, used for every sequence time
    function automatic logic reached(
        input logic [ssc_pkg::CNT_W-1:0] cnt,
        input longint unsigned limit
    );
        reached = (longint'(cnt) >= limit);
    endfunction

    ssc_pkg::ssc_state_t state_reg;
    ssc_pkg::ssc_state_t state_next;
    logic halt_reg, halt_next;
    logic check_reg, check_next;
    logic seqUp_reg, seqUp_next;
    logic seqDown_reg, seqDown_next;
    logic spindle_reg, spindle_next;
    logic retract_reg, retract_next;
    logic [1:0] pulseCnt_reg, pulseCnt_next;
    logic pullBack_reg, pullBack_next;
    logic brake_reg, brake_next;
    logic brakeCur_reg, brakeCur_next;
    logic doorLock_reg, doorLock_next;
    logic inhibit_reg, inhibit_next;
    logic lamp_reg, lamp_next;
    logic timerRestart;
    logic [ssc_pkg::CNT_W-1:0] seqCount;
    logic startPermitted;
    logic haltCause;
    logic beginUp;
    logic beginDown;

    ssc_seq_timer u_timer (
        .clk(clk),
        .rstSync_b(rstSync_b),
        .restart(timerRestart),
        .count(seqCount)
    );

    // Internal permit; never driven out
    always_comb begin
        startPermitted = !faults.dcFaultFlag && !halt_reg &&
            doorSecured && doorClosed && runRequest;
    end

    // Abnormal halt causes, gathered into one term
    always_comb begin
        haltCause = faults.emergencyPullbackActive ||
            faults.emergencyPullbackPowerLost;
        haltCause = haltCause || faults.recalFailedTwice;
        haltCause = haltCause ||
            (faults.seekNotDone && headsParked);
        haltCause = haltCause ||
            (headsParked && faults.servoHeadsOnDisc);
        haltCause = haltCause ||
            (check_reg && !atRatedSpeed);
    end

    // Start and stop decisions
    always_comb begin
        beginUp = (state_reg == ssc_pkg::SSC_STOPPED) && startPermitted &&
            !otherDriveInhibit && headsParked &&
            !atRatedSpeed;
        // Low permit in UP/RUN fires once; the state then leaves
        beginDown = !startPermitted &&
            ((state_reg == ssc_pkg::SSC_UP) ||
             (state_reg == ssc_pkg::SSC_RUN));
        timerRestart = beginUp || beginDown;
    end

    // Next-state logic for the sequencer and its flops
    always_comb begin
        state_next = state_reg;
        halt_next = halt_reg || haltCause;
        check_next = check_reg;
        seqUp_next = seqUp_reg;
        seqDown_next = seqDown_reg;
        spindle_next = spindle_reg;
        retract_next = 1'b0;
        pulseCnt_next = pulseCnt_reg;
        pullBack_next = pullBack_reg;
        brake_next = brake_reg;
        brakeCur_next = brakeCur_reg;
        doorLock_next = doorLock_reg;
        inhibit_next = inhibit_reg;
        // Retract pulse stretched to its minimum length
        if (pulseCnt_reg != 2'h0) begin
            retract_next = 1'b1;
            pulseCnt_next = pulseCnt_reg - 2'h1;
        end
        unique case (state_reg)
            ssc_pkg::SSC_STOPPED: begin
                if (beginUp) begin
                    state_next = ssc_pkg::SSC_UP;
                    seqUp_next = 1'b1;
                    seqDown_next = 1'b0;
                    spindle_next = 1'b1;
                    retract_next = 1'b1;
                    pulseCnt_next = 2'(ssc_pkg::RETRACT_PULSE_CYC - 1);
                    check_next = 1'b0;
                    pullBack_next = 1'b0;
                    brake_next = 1'b0;
                    brakeCur_next = 1'b0;
                    doorLock_next = 1'b1;
                    inhibit_next = 1'b1;
                end
            end
            ssc_pkg::SSC_UP, ssc_pkg::SSC_RUN: begin
                if (beginDown) begin
                    state_next = ssc_pkg::SSC_DOWN;
                    seqUp_next = 1'b0;
                    seqDown_next = 1'b1;
                    retract_next = 1'b1;
                    pullBack_next = 1'b1;
                    inhibit_next = 1'b0;
                end else if (state_reg == ssc_pkg::SSC_UP) begin
                    // Inhibit dropped once rated speed seen
                    if (atRatedSpeed) begin
                        inhibit_next = 1'b0;
                    end
                    if (reached(seqCount, ssc_pkg::SPEED_CHECK_CYC)) begin
                        check_next = 1'b1;
                        inhibit_next = 1'b0;
                        state_next = ssc_pkg::SSC_RUN;
                    end
                end
            end
            ssc_pkg::SSC_DOWN: begin
                // Spindle cut only once a retract flop already stands
                if (pullBack_reg || retract_reg) begin
                    spindle_next = 1'b0;
                end
                if (reached(seqCount, ssc_pkg::BRAKE_ENGAGE_CYC)) begin
                    brake_next = 1'b1;
                end
                if (reached(seqCount, ssc_pkg::BRAKE_CURRENT_CYC)) begin
                    brakeCur_next = 1'b1;
                end
                if (reached(seqCount, ssc_pkg::DOOR_RELEASE_CYC)) begin
                    doorLock_next = 1'b0;
                    brake_next = 1'b0;
                    brakeCur_next = 1'b0;
                    pullBack_next = 1'b0;
                    seqDown_next = 1'b0;
                    check_next = 1'b0;
                    state_next = ssc_pkg::SSC_STOPPED;
                end
            end
        endcase
        // Lamp lit only with door closed and secured
        lamp_next = doorClosed && doorSecured;
    end

    // Register all sequencer state
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state_reg <= ssc_pkg::SSC_STOPPED;
            halt_reg <= 1'b0;
            check_reg <= 1'b0;
            seqUp_reg <= 1'b0;
            seqDown_reg <= 1'b0;
            spindle_reg <= 1'b0;
            retract_reg <= 1'b0;
            pulseCnt_reg <= 2'h0;
            pullBack_reg <= 1'b0;
            brake_reg <= 1'b0;
            brakeCur_reg <= 1'b0;
            doorLock_reg <= 1'b0;
            inhibit_reg <= 1'b0;
            lamp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            halt_reg <= halt_next;
            check_reg <= check_next;
            seqUp_reg <= seqUp_next;
            seqDown_reg <= seqDown_next;
            spindle_reg <= spindle_next;
            retract_reg <= retract_next;
            pulseCnt_reg <= pulseCnt_next;
            pullBack_reg <= pullBack_next;
            brake_reg <= brake_next;
            brakeCur_reg <= brakeCur_next;
            doorLock_reg <= doorLock_next;
            inhibit_reg <= inhibit_next;
            lamp_reg <= lamp_next;
        end
    end

    // Outputs straight from flops
    always_comb begin
        drive.spindleRun = spindle_reg;
        drive.pullHeadsBack = pullBack_reg;
        drive.brakeEngage = brake_reg;
        drive.brakeCurrentDrive = brakeCur_reg;
        drive.doorLockDrive = doorLock_reg;
        drive.startInhibitOut = inhibit_reg;
    end

    assign doorLockedLamp = lamp_reg;
    assign abnormalHalt = halt_reg;
    assign speedCheckDone = check_reg;
    assign sequenceUp = seqUp_reg;
    assign sequenceDown = seqDown_reg;
endmodule

/* File: test/ssc_checker_assertions.sv */
// Port-level checker for the spindle sequence controller
`timescale 1ns/1ps
module ssc_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire ssc_pkg::ssc_faults_t faults,
    input wire logic runRequest,
    input wire logic doorClosed,
    input wire logic doorSecured,
    input wire logic headsParked,
    input wire logic atRatedSpeed,
    input wire logic otherDriveInhibit,
    input wire ssc_pkg::ssc_drive_t drive,
    input wire logic doorLockedLamp,
    input wire logic abnormalHalt,
    input wire logic speedCheckDone,
    input wire logic sequenceUp,
    input wire logic sequenceDown
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [1:0] relCnt_reg;
    logic ready;
    logic permit;
    // Inputs only count once the reset synchroniser has let go
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            relCnt_reg <= 2'h0;
        end else if (relCnt_reg != 2'h3) begin
            relCnt_reg <= relCnt_reg + 2'h1;
        end
    end
    assign ready = (relCnt_reg == 2'h3);
    assign permit = !faults.dcFaultFlag && !abnormalHalt && doorSecured &&
        doorClosed && runRequest;
    chk_up_gate: assert property ($rose(sequenceUp) |->
        $past(permit && !otherDriveInhibit && headsParked && !atRatedSpeed))
        else $error("up sequence began without its start terms");
    chk_up_outputs: assert property ($rose(sequenceUp) |->
        drive.spindleRun && drive.doorLockDrive && drive.startInhibitOut &&
        !sequenceDown) else $error("up sequence outputs missing");
    chk_check_clear: assert property ($rose(sequenceUp) |->
        !speedCheckDone) else $error("speed check flag left set at start");
    chk_down_entry: assert property (
        drive.spindleRun && !sequenceDown && !permit |=>
        sequenceDown && drive.pullHeadsBack)
        else $error("down sequence not entered on lost permit");
    chk_spindle_late: assert property ($rose(sequenceDown) |->
        drive.spindleRun ##1 !drive.spindleRun)
        else $error("spindle not cut one clock after retract");
    chk_brake_wait: assert property (
        $rose(sequenceDown) |->
        (!drive.brakeEngage && !drive.brakeCurrentDrive)[*8])
        else $error("brake applied too early");
    chk_door_held: assert property (
        drive.spindleRun |-> drive.doorLockDrive)
        else $error("door lock released while spinning");
    chk_lamp_dark: assert property (
        !doorClosed |=> !doorLockedLamp)
        else $error("lamp lit with door open");
    chk_inhibit_drop: assert property (drive.startInhibitOut &&
        atRatedSpeed |-> ##[1:2] !drive.startInhibitOut)
        else $error("inhibit held past rated speed");
    chk_halt_emerg: assert property (
        ready && (faults.recalFailedTwice ||
        faults.emergencyPullbackActive || faults.emergencyPullbackPowerLost)
        |=> abnormalHalt) else $error("servo fault not latched");
    chk_halt_heads: assert property (
        ready && headsParked && (faults.seekNotDone ||
        faults.servoHeadsOnDisc) |=> abnormalHalt)
        else $error("head contradiction not latched");
    chk_halt_stuck: assert property (
        abnormalHalt |=> abnormalHalt)
        else $error("halt latch cleared without reset");
endmodule
bind ssc_spindle_sequence_controller ssc_checker u_chk (.clk(clk),
    .rst_b(rst_b), .faults(faults), .runRequest(runRequest),
    .doorClosed(doorClosed), .doorSecured(doorSecured),
    .headsParked(headsParked), .atRatedSpeed(atRatedSpeed),
    .otherDriveInhibit(otherDriveInhibit), .drive(drive),
    .doorLockedLamp(doorLockedLamp), .abnormalHalt(abnormalHalt),
    .speedCheckDone(speedCheckDone), .sequenceUp(sequenceUp),
    .sequenceDown(sequenceDown));

/* File: test/ssc_far_side.sv */
// Far-side model: head actuator and baffle upspeed switch
`timescale 1ns/1ps
module ssc_far_side #(
    parameter int SPIN_CYC = 40
) (
    input wire logic clk,
    input wire ssc_pkg::ssc_drive_t drive,
    output logic headsParked,
    output logic atRatedSpeed
);
    int spinCnt = 0;
    // Pack speed stand-in; short so the baffle opens within the run
    always @(posedge clk) begin
        spinCnt <= drive.spindleRun ? spinCnt + 1 : 0;
    end
    // Heads load a few clocks after spin-up and park on pullback
    assign headsParked = !drive.spindleRun || drive.pullHeadsBack ||
        spinCnt < 4;
    assign atRatedSpeed = spinCnt >= SPIN_CYC;
endmodule

/* File: test/ssc_spindle_sequence_controller_tb.sv */
// Testbench for the spindle sequence controller
`timescale 1ns/1ps
module ssc_spindle_sequence_controller_tb;
    logic clk = 0;
    logic rst_b = 0;
    ssc_pkg::ssc_faults_t faults = '0;
    ssc_pkg::ssc_drive_t drive;
    logic runRequest = 0;
    logic doorClosed = 1;
    logic doorSecured = 1;
    logic otherDriveInhibit = 0;
    logic headsParked, atRatedSpeed, doorLockedLamp, abnormalHalt;
    logic speedCheckDone, sequenceUp, sequenceDown;
    int bad_count = 0;
    int compares = 0;
    ssc_spindle_sequence_controller u_dut (.clk(clk), .rst_b(rst_b),
        .faults(faults), .runRequest(runRequest), .doorClosed(doorClosed),
        .doorSecured(doorSecured), .headsParked(headsParked),
        .atRatedSpeed(atRatedSpeed), .otherDriveInhibit(otherDriveInhibit),
        .drive(drive), .doorLockedLamp(doorLockedLamp),
        .abnormalHalt(abnormalHalt), .speedCheckDone(speedCheckDone),
        .sequenceUp(sequenceUp), .sequenceDown(sequenceDown));
    ssc_far_side #(.SPIN_CYC(40)) u_far (.clk(clk), .drive(drive),
        .headsParked(headsParked), .atRatedSpeed(atRatedSpeed));
    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic results;
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Full reset; the only way out of a down sequence in a short run
    task automatic do_reset;
        rst_b = 0;
        faults = '0;
        // Power-on fault window, shortened to a few clocks
        faults.dcFaultFlag = 1'b1;
        runRequest = 0;
        doorClosed = 1;
        doorSecured = 1;
        otherDriveInhibit = 0;
        tick(16);
        rst_b = 1;
        tick(4);
        faults.dcFaultFlag = 1'b0;
        tick(1);
    endtask
    // Ask for a start and wait a bounded time for the up sequence
    task automatic start_up;
        int i;
        runRequest = 1;
        for (i = 0; i < 10 && sequenceUp !== 1'b1; i++) tick(1);
        if (i == 10) begin
            bad_count++;
            results;
        end
    endtask
    initial begin
        do_reset;
        // Run, door closed, door secured, DC fault and inhibit each alone keep the drive stopped
        for (int k = 0; k < 5; k++) begin
            runRequest = (k != 0);
            doorClosed = (k != 1);
            doorSecured = (k != 2);
            faults.dcFaultFlag = (k == 3);
            otherDriveInhibit = (k == 4);
            tick(4);
            check({1'b0, sequenceUp, drive}, 8'h00);
            check({7'h0, doorLockedLamp}, 8'(k != 1 && k != 2));
        end
        // Clean start, inhibit drops at speed, then operator stop
        faults = '0;
        otherDriveInhibit = 0;
        start_up;
        check({2'h0, drive}, 8'h23);
        tick(50);
        check({2'h0, drive}, 8'h22);
        // Check time is far beyond this run, so the flag must stay low
        check({7'h0, speedCheckDone}, 8'h00);
        runRequest = 0;
        tick(1);
        check({sequenceDown, sequenceUp, drive}, 8'hB2);
        tick(1);
        check({2'h0, drive}, 8'h12);
        runRequest = 1;
        tick(4);
        check({7'h0, sequenceUp}, 8'h00);
        // Door opened while running
        do_reset;
        start_up;
        tick(10);
        doorClosed = 0;
        tick(1);
        check({5'h0, sequenceDown, drive.pullHeadsBack,
            doorLockedLamp}, 8'h06);
        // Each halt cause except the slow speed check latches and blocks a later start
        for (int k = 0; k < 5; k++) begin
            do_reset;
            faults = 6'h10 >> k;
            tick(2);
            check(8'(abnormalHalt), 8'h01);
            faults = '0;
            runRequest = 1;
            tick(4);
            check({6'h0, abnormalHalt, sequenceUp}, 8'h02);
        end
        // Halt while running forces the down sequence; reset clears halt, down sequence and drive
        do_reset;
        start_up;
        tick(10);
        faults.emergencyPullbackActive = 1;
        tick(3);
        check({6'h0, sequenceDown, drive.pullHeadsBack},
            8'h03);
        do_reset;
        check({abnormalHalt, sequenceDown, drive}, 8'h00);
        results;
    end
endmodule
